// >>> design/csag_pkg.sv
package csag_pkg;
    // widths of the address and data paths, and the state count
    localparam int ADDR_W     = 14;   // control store address width
    localparam int CSAR_W     = 16;   // address register width, bit 00 is msb
    localparam int LOW_W      = 12;   // constant low part of fixed entries
    localparam int TBL_ADDR_W = 10;   // widest address table (1024 words)
    localparam int TBL_ENC_W  = 8;    // encoded fan-in address width
    localparam int DATA_W     = 16;   // fan-in and bus data width
    localparam int NUM_STATES = 10;   // processor states incl. console
    localparam int REG_ADDR_W = 4;    // register port address width

    // low parts of the quarter-relative entries
    localparam logic [LOW_W-1:0] LOW_FETCH2  = 12'h002;
    localparam logic [LOW_W-1:0] LOW_FETCH3  = 12'h009;
    localparam logic [LOW_W-1:0] LOW_ILLEGAL = 12'h010;
    localparam logic [LOW_W-1:0] LOW_MS_PAR  = 12'h018;
    localparam logic [LOW_W-1:0] LOW_CS_PAR  = 12'h028;

    // absolute console and autoload entries
    localparam logic [ADDR_W-1:0] CON_GRP0    = 14'h0100;
    localparam logic [ADDR_W-1:0] CON_GRP1    = 14'h0103;
    localparam logic [ADDR_W-1:0] CON_GRP2    = 14'h0106;
    localparam logic [ADDR_W-1:0] CON_GRP3    = 14'h010C;
    localparam logic [ADDR_W-1:0] ALOAD_ALT   = 14'h0112;
    localparam logic [ADDR_W-1:0] ALOAD_PRI   = 14'h0113;

    // timing and state limits
    localparam logic [1:0] MIN_FANIN_MINORS = 2'h2;  // minors before table branch
    localparam logic [3:0] LAST_TRAP_STATE  = 4'h7;  // parity traps only up to here

    // register map
    localparam logic [REG_ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h1;
    localparam logic [REG_ADDR_W-1:0] REG_CSAR   = 4'h2;
    localparam int CTRL_BKPT_BIT = 0;                 // breakpoint display select
    localparam int CTRL_SIZE_LSB = 1;                 // table size field, 2 bits
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

    // next-address source chosen by the microsequencer
    typedef enum logic [3:0] {
        SEL_HOLD   = 4'h0, SEL_BRANCH = 4'h1, SEL_FETCH2 = 4'h2, SEL_FETCH3 = 4'h3,
        SEL_CON0   = 4'h4, SEL_CON1   = 4'h5, SEL_CON2   = 4'h6, SEL_CON3   = 4'h7,
        SEL_ALT    = 4'h8, SEL_PRI    = 4'h9
    } addr_sel_e;

    // trap kinds, also reported in status
    typedef enum logic [1:0] {
        TRAP_NONE = 2'h0, TRAP_ILLEGAL = 2'h1, TRAP_MS_PAR = 2'h2, TRAP_CS_PAR = 2'h3
    } trap_e;

    // table-branch setup sequence
    typedef enum logic [1:0] {
        TB_IDLE = 2'h0, TB_SETUP = 2'h1, TB_READY = 2'h2
    } tb_state_e;

    // storage error reports from main and control storage
    typedef struct packed {
        logic csParity;        // control store parity error
        logic msParity;        // main storage read parity error
        logic msOutOfRange;    // out-of-range main storage address
        logic msUncorrectable; // uncorrectable error with correction fitted
        logic addrViolation;   // main storage address violation
        logic violationEnable; // violation trapping enabled
    } trap_cond_s;

    // processor cycle timing pulses
    typedef struct packed {
        logic majorStart;      // first clock of a major cycle
        logic minorTick;       // one clock per minor cycle
        logic minorE7;         // minor cycle E7
    } timing_s;
endpackage

// >>> design/control_store_address_generation.sv
// Summary of operation
// [RQ1] breakpoint display: bits 00,01 zero, then address
// [RQ2] console references: bit 00 selects table
// [RQ3] second fetch entry at quarter low 002
// [RQ4] third fetch entry at quarter low 009
// [RQ5] decode fetch entries at every major start
// [RQ6] enabled address violation traps to low 010
// [RQ7] main storage error traps to low 018
// [RQ8] control store parity traps to low 028
// [RQ9] parity disable switch suppresses parity traps
// [RQ10] precedence: cs parity, ms parity, illegal
// [RQ11] entry high two bits kept from quarter
// [RQ12] traps on E7, set state busy flag; the code sets the busy flag only in states 0 to 7
// [RQ13] no stop in major cycle with trap; the code holds off the stop only if the state at the boundary is 0 to 7
// [RQ14] console groups start at 0100/0103/0106/010C
// [RQ15] autoload alternate 0112, primary 0113
// [RQ16] table sizes 256 to 1024 ten-bit words
// [RQ17] fan-in addresses table two minors first
// [RQ18] ten fan-in bits encode eight address bits
// [RQ19] table parity odd over 00, 07-15
// [RQ20] encoded bits muxed only while branch pending
module control_store_address_generation #(
    parameter logic [11:0] FETCH1_LOW = 12'h000  // first fetch entry low part
) (
    input  wire logic                               clk,
    input  wire logic                               rst_b,
    input  wire csag_pkg::timing_s                  timing,
    input  wire logic [3:0]                         procState,
    input  wire logic                               consoleState,
    input  wire csag_pkg::addr_sel_e                addrSel,
    input  wire logic [csag_pkg::LOW_W-1:0]         branchLow,
    input  wire csag_pkg::trap_cond_s               trapCond,
    input  wire logic                               eccFitted,
    input  wire logic                               parityDisable,
    input  wire logic                               stopRequest,
    input  wire logic                               tableBranchPending,
    input  wire logic [0:csag_pkg::DATA_W-1]        dataFanIn,
    input  wire logic [0:csag_pkg::DATA_W-1]        tableData,
    input  wire logic [csag_pkg::REG_ADDR_W-1:0]    regAddr,
    input  wire logic [csag_pkg::DATA_W-1:0]        regWrData,
    input  wire logic                               regWr,
    input  wire logic                               regRd,
    output logic [csag_pkg::DATA_W-1:0]             regRdData,
    output logic [csag_pkg::ADDR_W-1:0]             csAddr,
    output logic                                    csTargetTable,
    output logic [0:csag_pkg::DATA_W-1]             consoleAddrDisplay,
    output logic [csag_pkg::TBL_ADDR_W-1:0]         tableAddr,
    output logic                                    tableParityOk,
    output logic                                    tableBranchReady,
    output logic                                    fetchEntryHit,
    output logic                                    trapTaken,
    output logic [csag_pkg::NUM_STATES-1:0]         busySet,
    output logic                                    stopGrant
);
    // address register, bit 00 on the left
    logic [0:csag_pkg::CSAR_W-1]  csar_reg;
    logic [csag_pkg::DATA_W-1:0]  ctrl_reg;          // software control
    logic                         pendCs_reg;        // cs parity seen this major
    logic                         pendMs_reg;        // ms error seen this major
    logic                         pendIll_reg;       // violation seen this major
    logic                         trapSeen_reg;      // trap fired this major
    csag_pkg::trap_e              lastTrap_reg;      // kind of most recent trap
    csag_pkg::tb_state_e          tb_reg;            // table-branch setup state
    logic [1:0]                   minorCnt_reg;      // minors of fan-in addressing
    csag_pkg::trap_e              trap_next;         // trap chosen this clock
    logic [csag_pkg::ADDR_W-1:0]  addr14;            // current 14-bit address
    logic [1:0]                   quarter;           // current high two bits
    logic                         parityState;       // state may take parity traps
    logic                         msError;           // qualified ms error
    logic [csag_pkg::TBL_ENC_W-1:0] encoded;         // encoded fan-in
    logic [csag_pkg::TBL_ADDR_W-1:0] sizeMask;       // fitted table size mask
    logic                         consoleWrCsar;     // console loads the register

    assign addr14        = csar_reg[2:csag_pkg::CSAR_W-1];
    assign quarter       = csar_reg[2:3];
    assign parityState   = (procState <= csag_pkg::LAST_TRAP_STATE);
    assign consoleWrCsar = regWr && consoleState && (regAddr == csag_pkg::REG_CSAR);

    // out-of-range counts only without correction, uncorrectable only with it
    assign msError = trapCond.msParity
                   || (!eccFitted && trapCond.msOutOfRange)
                   || (eccFitted && trapCond.msUncorrectable);  // [RQ7]

    // fan-in encoder into the low table address bits
    function automatic logic [7:0] encodeFanIn(input logic [0:15] df);
        logic [3:0] lo;
        logic       isB;
        logic       isA;
        lo  = df[4:7];
        isB = (lo == 4'hB) || (lo >= 4'hC);
        isA = (lo == 4'hA) || (lo >= 4'hC);
        unique case (df[0:3])
            4'h2, 4'h3, 4'hA, 4'hB: encodeFanIn = {2'b00, df[0], df[3], isB, isA, df[8], df[12]};
            4'h6, 4'h7:             encodeFanIn = {3'b010, df[3], df[4], df[5], df[8], df[12]};
            4'hE:                   encodeFanIn = {2'b10, df[4], df[5], df[6], df[7], df[8], df[12]};
            4'hF:                   encodeFanIn = {2'b11, df[4], df[5], df[6], df[7], df[8], df[12]};
            default:                encodeFanIn = {3'b011, df[0], df[1], df[3], df[4], df[5]};
        endcase
    endfunction

    assign encoded = encodeFanIn(dataFanIn);  // [RQ18]

    // fitted table size: 256, 512, 768 or 1024 words
    always_comb begin
        unique case (ctrl_reg[csag_pkg::CTRL_SIZE_LSB +: 2])
            2'h0:    sizeMask = 10'h0FF;
            2'h1:    sizeMask = 10'h1FF;
            default: sizeMask = 10'h3FF;   // 768 decodes as 1024, top quarter unused
        endcase
    end  // [RQ16]

    // trap selection on E7 in fixed precedence
    always_comb begin
        trap_next = csag_pkg::TRAP_NONE;
        if (timing.minorE7 && !consoleState) begin  // [RQ12]
            if (pendCs_reg && parityState && !parityDisable) begin  // [RQ8] [RQ9]
                trap_next = csag_pkg::TRAP_CS_PAR;  // [RQ10]
            end else if (pendMs_reg && parityState && !parityDisable) begin  // [RQ7] [RQ9]
                trap_next = csag_pkg::TRAP_MS_PAR;
            end else if (pendIll_reg) begin  // [RQ6]
                trap_next = csag_pkg::TRAP_ILLEGAL;
            end
        end
    end

    // conditions gathered across the major cycle, set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pendCs_reg  <= 1'b0;
            pendMs_reg  <= 1'b0;
            pendIll_reg <= 1'b0;
        end else begin
            pendCs_reg  <= trapCond.csParity || (pendCs_reg && !timing.majorStart);
            // ms parity ignored while a violation is present
            pendMs_reg  <= (msError && !trapCond.addrViolation)
                           || (pendMs_reg && !timing.majorStart);  // [RQ10]
            pendIll_reg <= (trapCond.addrViolation && trapCond.violationEnable)
                           || (pendIll_reg && !timing.majorStart);  // [RQ6]
        end
    end

    // address register: traps, microcommand entries, console loads
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            csar_reg <= '0;
        end else if (consoleState) begin
            // microcommand sources are shut out in console state
            if (consoleWrCsar) begin
                csar_reg <= regWrData;  // [RQ2]
            end
        end else if (trap_next != csag_pkg::TRAP_NONE) begin
            unique case (trap_next)
                csag_pkg::TRAP_CS_PAR: csar_reg[2:15] <= {quarter, csag_pkg::LOW_CS_PAR};  // [RQ8] [RQ11]
                csag_pkg::TRAP_MS_PAR: csar_reg[2:15] <= {quarter, csag_pkg::LOW_MS_PAR};  // [RQ7] [RQ11]
                default:               csar_reg[2:15] <= {quarter, csag_pkg::LOW_ILLEGAL}; // [RQ6] [RQ11]
            endcase
        end else begin
            unique case (addrSel)
                csag_pkg::SEL_HOLD:   csar_reg <= csar_reg;
                csag_pkg::SEL_BRANCH: csar_reg[2:15] <= {quarter, branchLow};
                csag_pkg::SEL_FETCH2: csar_reg[2:15] <= {quarter, csag_pkg::LOW_FETCH2};  // [RQ3] [RQ11]
                csag_pkg::SEL_FETCH3: csar_reg[2:15] <= {quarter, csag_pkg::LOW_FETCH3};  // [RQ4] [RQ11]
                csag_pkg::SEL_CON0:   csar_reg[2:15] <= csag_pkg::CON_GRP0;   // [RQ14]
                csag_pkg::SEL_CON1:   csar_reg[2:15] <= csag_pkg::CON_GRP1;   // [RQ14]
                csag_pkg::SEL_CON2:   csar_reg[2:15] <= csag_pkg::CON_GRP2;   // [RQ14]
                csag_pkg::SEL_CON3:   csar_reg[2:15] <= csag_pkg::CON_GRP3;   // [RQ14]
                csag_pkg::SEL_ALT:    csar_reg[2:15] <= csag_pkg::ALOAD_ALT;  // [RQ15]
                csag_pkg::SEL_PRI:    csar_reg[2:15] <= csag_pkg::ALOAD_PRI;  // [RQ15]
                default:              csar_reg <= csar_reg;  // undefined codes hold
            endcase
        end
    end

    // trap bookkeeping: busy flag, trap pulse, stop inhibit, kind
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trapTaken    <= 1'b0;
            busySet      <= '0;
            trapSeen_reg <= 1'b0;
            lastTrap_reg <= csag_pkg::TRAP_NONE;
        end else begin
            trapTaken <= (trap_next != csag_pkg::TRAP_NONE);
            busySet   <= '0;
            if ((trap_next != csag_pkg::TRAP_NONE) && parityState) begin
                busySet[procState] <= 1'b1;  // [RQ12]
            end
            if (trap_next != csag_pkg::TRAP_NONE) begin
                lastTrap_reg <= trap_next;
            end
            // a trap in the same clock as major start belongs to the new cycle
            trapSeen_reg <= (trap_next != csag_pkg::TRAP_NONE)
                            || (trapSeen_reg && !timing.majorStart);
        end
    end

    // stop at a major cycle boundary unless the ending cycle trapped and procState is at most 7
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stopGrant <= 1'b0;
        end else begin
            stopGrant <= timing.majorStart && stopRequest
                         && !(trapSeen_reg && parityState);  // [RQ13]
        end
    end

    // fetch entry decode, sampled once per major cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fetchEntryHit <= 1'b0;
        end else if (timing.majorStart) begin
            fetchEntryHit <= (addr14[11:0] == FETCH1_LOW)
                             || (addr14[11:0] == csag_pkg::LOW_FETCH2)
                             || (addr14[11:0] == csag_pkg::LOW_FETCH3);  // [RQ5]
        end
    end

    // console address display and target select
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            consoleAddrDisplay <= '0;
            csTargetTable      <= 1'b0;
            csAddr             <= '0;
        end else begin
            csAddr        <= addr14;
            csTargetTable <= consoleState && csar_reg[0];  // [RQ2]
            if (ctrl_reg[csag_pkg::CTRL_BKPT_BIT] && !consoleState) begin
                consoleAddrDisplay <= {2'b00, addr14};  // [RQ1]
            end else begin
                consoleAddrDisplay <= csar_reg;
            end
        end
    end

    // table-branch setup: fan-in must address the table two minors
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tb_reg       <= csag_pkg::TB_IDLE;
            minorCnt_reg <= '0;
        end else if (!tableBranchPending || consoleState) begin
            tb_reg       <= csag_pkg::TB_IDLE;
            minorCnt_reg <= '0;
        end else begin
            unique case (tb_reg)
                csag_pkg::TB_IDLE: begin
                    tb_reg       <= csag_pkg::TB_SETUP;
                    minorCnt_reg <= '0;
                end
                csag_pkg::TB_SETUP: begin
                    // count only whole minors after the mux switched
                    if (timing.minorTick) begin
                        minorCnt_reg <= minorCnt_reg + 2'h1;
                        if (minorCnt_reg + 2'h1 >= csag_pkg::MIN_FANIN_MINORS) begin
                            tb_reg <= csag_pkg::TB_READY;  // [RQ17]
                        end
                    end
                end
                csag_pkg::TB_READY: tb_reg <= csag_pkg::TB_READY;
                default:            tb_reg <= csag_pkg::TB_IDLE;
            endcase
        end
    end

    // table address path, fan-in only while a branch is pending
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tableAddr        <= '0;
            tableBranchReady <= 1'b0;
            tableParityOk    <= 1'b0;
        end else begin
            tableBranchReady <= (tb_reg == csag_pkg::TB_READY);  // [RQ17]
            if (tableBranchPending && !consoleState) begin
                // encoded bits replace the right-most register bits
                tableAddr <= {addr14[9:8], encoded} & sizeMask;  // [RQ18] [RQ20]
            end else begin
                tableAddr <= addr14[9:0] & sizeMask;  // [RQ20]
            end
            // bits 01-06 carry no parity weight
            tableParityOk <= ^{tableData[0], tableData[7:15]};  // [RQ19]
        end
    end

    // software control register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= csag_pkg::CTRL_RESET;
        end else if (regWr && (regAddr == csag_pkg::REG_CTRL)) begin
            ctrl_reg <= regWrData;
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                csag_pkg::REG_CTRL:   regRdData <= ctrl_reg;
                csag_pkg::REG_STATUS: regRdData <= {8'h00, tb_reg, lastTrap_reg, fetchEntryHit,
                                                    pendCs_reg, pendMs_reg, pendIll_reg};
                csag_pkg::REG_CSAR:   regRdData <= csar_reg;
                default:              regRdData <= '0;  // unmapped reads zero
            endcase
        end else begin
            regRdData <= '0;
        end
    end

    // checks
    a_cs_parity_trap: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ8]
        (timing.minorE7 && !consoleState && pendCs_reg && parityState && !parityDisable)
        |=> (csar_reg[4:15] == csag_pkg::LOW_CS_PAR) && trapTaken)
        else $error("cs parity trap address wrong");

    a_parity_disabled: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ9]
        (parityDisable && !pendIll_reg) |=> !trapTaken)
        else $error("parity trap taken while disabled");

    a_ms_trap_addr: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ7]
        (trap_next == csag_pkg::TRAP_MS_PAR) |=> (csar_reg[4:15] == csag_pkg::LOW_MS_PAR))
        else $error("ms parity trap address wrong");

    a_illegal_quarter: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ11]
        (trap_next == csag_pkg::TRAP_ILLEGAL) |=> (csar_reg[2:3] == $past(quarter))
        && (csar_reg[4:15] == csag_pkg::LOW_ILLEGAL))
        else $error("illegal trap lost quarter");

    a_trap_on_e7: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ12]
        trapTaken |-> $past(timing.minorE7))
        else $error("trap outside minor E7");

    a_no_stop_trap: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ13]
        (trapSeen_reg && parityState && timing.majorStart) |=> !stopGrant)
        else $error("stop granted after trap");

    a_fanin_two_minors: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ17]
        $rose(tableBranchReady) |-> $past(minorCnt_reg, 2) >= 2'h1)
        else $error("table branch ready too early");

    a_bkpt_display: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ1]
        (ctrl_reg[csag_pkg::CTRL_BKPT_BIT] && !consoleState)
        |=> (consoleAddrDisplay[0:1] == 2'b00) && (consoleAddrDisplay[2:15] == $past(addr14)))
        else $error("breakpoint display format wrong");

    a_autoload_pri: assert property (@(posedge clk) disable iff (!rst_b)  // [RQ15]
        (addrSel == csag_pkg::SEL_PRI && !consoleState && trap_next == csag_pkg::TRAP_NONE)
        |=> addr14 == csag_pkg::ALOAD_PRI ##1 csAddr == csag_pkg::ALOAD_PRI)
        else $error("primary autoload entry wrong");
endmodule  // control_store_address_generation

// >>> tb/tb_control_store_address_generation.sv
module tb_control_store_address_generation;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, consoleState = 1'b0, eccFitted = 1'b0, parityDisable = 1'b0;
    logic stopRequest = 1'b1, tableBranchPending = 1'b0, regWr = 1'b0, regRd = 1'b0;
    csag_pkg::timing_s    timing = '0;      // cycle timing pulses
    csag_pkg::trap_cond_s trapCond = '0;    // storage error reports
    csag_pkg::addr_sel_e  addrSel = csag_pkg::SEL_HOLD;
    logic [3:0] procState = 4'h0, regAddr = 4'h0;
    logic [11:0] branchLow = 12'h000;
    logic [0:15] dataFanIn = 16'h0000, tableData = 16'h0000;
    logic [15:0] regWrData = 16'h0000, regRdData, csDisp;
    logic [13:0] csAddr;
    logic [9:0] tableAddr, busySet;
    logic csTargetTable, tableParityOk, tableBranchReady, fetchEntryHit, trapTaken, stopGrant;
    int fails = 0, comparisons = 0, cycles = 0;
    control_store_address_generation i_control_store_address_generation (.clk(clk), .rst_b(rst_b),
        .timing(timing), .procState(procState), .consoleState(consoleState), .addrSel(addrSel),
        .branchLow(branchLow), .trapCond(trapCond), .eccFitted(eccFitted), .parityDisable(parityDisable),
        .stopRequest(stopRequest), .tableBranchPending(tableBranchPending), .dataFanIn(dataFanIn),
        .tableData(tableData), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .csAddr(csAddr), .csTargetTable(csTargetTable), .consoleAddrDisplay(csDisp),
        .tableAddr(tableAddr), .tableParityOk(tableParityOk), .tableBranchReady(tableBranchReady),
        .fetchEntryHit(fetchEntryHit), .trapTaken(trapTaken), .busySet(busySet), .stopGrant(stopGrant));
    // free-running bench clock, 100 ns period
    always #50 clk = ~clk;
    // hang guard: whole run is about 130 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    // one-cycle strobes, data taken the cycle after the read strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
        @(posedge clk) regRd <= 1'b0;
        #1 chk(regRdData, exp, "register read");
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
        @(posedge clk) regWr <= 1'b0;
    endtask
    // load one address source, then let the registered copy settle
    task automatic sel(input csag_pkg::addr_sel_e s);
        @(posedge clk) addrSel <= s;
        @(posedge clk) addrSel <= csag_pkg::SEL_HOLD;
        @(posedge clk) #1;
    endtask
    // major cycle boundary; stop grant looked for over two cycles
    task automatic major(input logic exp);
        logic g;
        @(posedge clk) timing.majorStart <= 1'b1;
        @(posedge clk) timing.majorStart <= 1'b0;
        #1 g = stopGrant;
        @(posedge clk) #1 g = g | stopGrant;
        chk({15'h0, g}, {15'h0, exp}, "stop grant");
    endtask
    // condition one clock, then an E7 pulse two clocks later
    task automatic trap(input logic [5:0] c, input logic [3:0] st, input logic pd, input logic tk,
                        input logic [11:0] low);
        @(posedge clk) begin trapCond <= c; procState <= st; parityDisable <= pd; end
        @(posedge clk) trapCond <= '0;
        @(posedge clk) timing.minorE7 <= 1'b1;
        @(posedge clk) timing.minorE7 <= 1'b0;
        #1 chk({15'h0, trapTaken}, {15'h0, tk}, "trap taken");
        chk({6'h0, busySet}, tk ? (16'h0001 << st) : 16'h0000, "busy flag");
        @(posedge clk) #1;
        if (tk) chk({4'h0, csAddr[11:0]}, {4'h0, low}, "trap address");
        major(!tk);
    endtask
    task automatic conclude();
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // fixed entries, table of source against expected full address
    csag_pkg::addr_sel_e srcs [6] = '{csag_pkg::SEL_CON0, csag_pkg::SEL_CON1, csag_pkg::SEL_CON2,
                                      csag_pkg::SEL_CON3, csag_pkg::SEL_ALT, csag_pkg::SEL_PRI};
    logic [13:0] ents [6] = '{csag_pkg::CON_GRP0, csag_pkg::CON_GRP1, csag_pkg::CON_GRP2,
                              csag_pkg::CON_GRP3, csag_pkg::ALOAD_ALT, csag_pkg::ALOAD_PRI};
    logic [0:15] words [3] = '{16'h0000, 16'h8001, 16'h03F0};  // table words for parity
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(csag_pkg::REG_CTRL, csag_pkg::CTRL_RESET);
        rd(4'hF, 16'h0000);
        wr(csag_pkg::REG_CTRL, 16'h0001);
        rd(csag_pkg::REG_CTRL, 16'h0001);
        sel(csag_pkg::SEL_FETCH2);
        chk({4'h0, csAddr[11:0]}, {4'h0, csag_pkg::LOW_FETCH2}, "second fetch entry");
        major(1'b1);
        chk({15'h0, fetchEntryHit}, 16'h0001, "fetch entry decode");
        sel(csag_pkg::SEL_FETCH3);
        chk({4'h0, csAddr[11:0]}, {4'h0, csag_pkg::LOW_FETCH3}, "third fetch entry");
        foreach (srcs[i]) begin
            sel(srcs[i]);
            chk({2'b00, csAddr}, {2'b00, ents[i]}, "console or autoload entry");
            chk(csDisp, {2'b00, ents[i]}, "breakpoint display");
        end
        major(1'b1);
        chk({15'h0, fetchEntryHit}, 16'h0000, "fetch entry decode");
        trap(6'h33, 4'h2, 1'b0, 1'b1, csag_pkg::LOW_CS_PAR);
        trap(6'h13, 4'h5, 1'b0, 1'b1, csag_pkg::LOW_ILLEGAL);
        trap(6'h10, 4'h7, 1'b0, 1'b1, csag_pkg::LOW_MS_PAR);
        trap(6'h08, 4'h0, 1'b0, 1'b1, csag_pkg::LOW_MS_PAR);
        // with correction fitted out-of-range errors no longer trap, uncorrectable ones do
        @(posedge clk) eccFitted <= 1'b1;
        trap(6'h08, 4'h3, 1'b0, 1'b0, 12'h000);
        trap(6'h04, 4'h3, 1'b0, 1'b1, csag_pkg::LOW_MS_PAR);
        trap(6'h20, 4'h1, 1'b1, 1'b0, 12'h000);
        trap(6'h20, 4'h8, 1'b0, 1'b0, 12'h000);
        foreach (words[i]) begin
            @(posedge clk) tableData <= words[i];
            @(posedge clk) #1;
            chk({15'h0, tableParityOk}, {15'h0, ~^{words[i][0], words[i][7:15]} ^ 1'b1}, "table parity");
        end
        // fan-in 0xF6C8 encodes to table address 0xDB in a 256-word table
        @(posedge clk) begin tableBranchPending <= 1'b1; dataFanIn <= 16'hF6C8; end
        @(posedge clk) timing.minorTick <= 1'b1;
        @(posedge clk) timing.minorTick <= 1'b0;
        #1 chk({15'h0, tableBranchReady}, 16'h0000, "branch ready early");
        chk({6'h0, tableAddr}, 16'h00DB, "table address from fan-in");
        @(posedge clk) timing.minorTick <= 1'b1;
        @(posedge clk) timing.minorTick <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0, tableBranchReady}, 16'h0001, "branch ready");
        rd(csag_pkg::REG_STATUS, 16'h00A0);
        // without a pending branch the register low bits address the table
        @(posedge clk) tableBranchPending <= 1'b0;
        @(posedge clk) #1 chk({6'h0, tableAddr}, 16'h0018, "table address from register");
        // console loads the register, bit 00 picks the address table
        @(posedge clk) consoleState <= 1'b1;
        wr(csag_pkg::REG_CSAR, 16'h8123);
        rd(csag_pkg::REG_CSAR, 16'h8123);
        chk({15'h0, csTargetTable}, 16'h0001, "console table target");
        chk(csDisp, 16'h8123, "console register display");
        conclude();
    end
endmodule // tb_control_store_address_generation
